// [pci_pin_model.sv]
// Model of the external signals on the port pins
module pci_pin_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Levels asked for by the bench
    input wire pcint_pkg::pcint_ports_type pin_req,
    // Levels on the pins
    output pcint_pkg::pcint_ports_type pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Next pin levels
    pcint_pkg::pcint_ports_type next_pin_level;
    // Pins follow the request, each pin on its own
    always_comb begin
        next_pin_level = pin_req;
    end
    // Register the pin levels
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_level <= '0;
        end else begin
            pin_level <= next_pin_level;
        end
    end
endmodule : pci_pin_model

// [pci_sva.sv]
// Bus and wake checker of the pin change block
module pci_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Block ports
    input wire pcint_pkg::pcint_ports_type pin_level,
    input wire logic sleep_active,
    input wire pcint_pkg::pcint_axi_req_type bus_req,
    input wire pcint_pkg::pcint_axi_rsp_type bus_rsp,
    input wire logic irq,
    input wire logic wake_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Address and data taken at one edge
    sequence wr_taken_s;
        bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready;
    endsequence
    // Hold cycle then response
    sequence wr_answer_s;
        !bus_rsp.bvalid ##1 bus_rsp.bvalid;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    aw_accept_a: assert property (bus_req.awvalid && bus_rsp.awready |=> !bus_rsp.awready)
        else $error("write address ready stayed high");
    wr_answer_a: assert property (wr_taken_s |=> wr_answer_s)
        else $error("write response not two edges after acceptance");
    bresp_hold_a: assert property (bus_rsp.bvalid && !bus_req.bready |=>
        bus_rsp.bvalid && $stable(bus_rsp.bresp))
        else $error("write response dropped before ready");
    rd_answer_a: assert property (bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid)
        else $error("read data not one edge after acceptance");
    rdata_hold_a: assert property (bus_rsp.rvalid && !bus_req.rready |=>
        bus_rsp.rvalid && $stable(bus_rsp.rdata))
        else $error("read data dropped before ready");
    rdata_width_a: assert property (bus_rsp.rvalid |-> bus_rsp.rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    slverr_zero_a: assert property (bus_rsp.rvalid && bus_rsp.rresp == 2'h2 |->
        bus_rsp.rdata == 32'h00000000)
        else $error("error read returned data");
    wake_sleep_a: assert property (wake_req |-> $past(sleep_active))
        else $error("wake request outside sleep");
endmodule : pci_sva

bind pcint_top pci_sva u_sva (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_level(pin_level),
    .sleep_active(sleep_active),
    .bus_req(bus_req),
    .bus_rsp(bus_rsp),
    .irq(irq),
    .wake_req(wake_req)
);

// [pcint_defs.svh]
// Register offsets, field positions and constants of the pin change block
`ifndef PCINT_DEFS_SVH
`define PCINT_DEFS_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define PCINT_OFS_A_RISE 6'h00
`define PCINT_OFS_A_FALL 6'h04
`define PCINT_OFS_A_FLAG 6'h08
`define PCINT_OFS_B_RISE 6'h0C
`define PCINT_OFS_B_FALL 6'h10
`define PCINT_OFS_B_FLAG 6'h14
`define PCINT_OFS_C_RISE 6'h18
`define PCINT_OFS_C_FALL 6'h1C
`define PCINT_OFS_C_FLAG 6'h20
`define PCINT_OFS_CTRL 6'h24
`define PCINT_OFS_EVT_STAT 6'h28
`define PCINT_OFS_EVT_MASK 6'h2C

// -----------------------------------------------------------------
// Fields, masks and reset values
// -----------------------------------------------------------------
`define PCINT_MASK_A 8'h3F
`define PCINT_MASK_B 8'hF0
`define PCINT_MASK_C 8'hFF
`define PCINT_BIT_MASTER_EN 0
`define PCINT_BIT_SUMMARY 1
`define PCINT_RST_BYTE 8'h00
`define PCINT_RST_EVT 3'h0
`define PCINT_RESP_OKAY 2'h0
`define PCINT_RESP_SLVERR 2'h2
`define PCINT_ADDR_LSB 2
`define PCINT_ADDR_MSB 5

`endif

// [pcint_pkg.sv]
// Types shared by the pin change block and its bench
package pcint_pkg;

    // -------------------------------------------------------------
    // Port data
    // -------------------------------------------------------------
    // Three ports of eight pin positions each
    typedef logic [2:0][7:0] pcint_ports_type;

    // -------------------------------------------------------------
    // AXI4-Lite carriers
    // -------------------------------------------------------------
    // Master to slave signals
    typedef struct packed {
        logic [5:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [5:0] araddr;
        logic arvalid;
        logic rready;
    } pcint_axi_req_type;

    // Slave to master signals
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pcint_axi_rsp_type;

endpackage : pcint_pkg

// [pcint_top.sv]
// Pin change detector with per-pin flags and an AXI4-Lite register slave
`include "pcint_defs.svh"

// Summary of operation
// - Every implemented pin of every port individually selectable
// - Flags still set while master disabled
// - Rising detector gated by rising enable bit
// - Falling detector gated by falling enable bit
// - Both enables set on a pin detect both edge directions
// - Enabled edge sets flag, interrupts if enabled
// - Summary flag is OR of all flags
// - Writing zero clears a pin flag
// - Edge during flag write leaves flag set
// - Edge in sleep wakes device if enabled
// - Flag updated before wake request is seen
// - First port implements pins five to zero
// - Second port implements pins seven to four
// - Flag set by enabled matching edge or by writing one to it
module pcint_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Port pins, asynchronous levels synchronised by two flops
    input wire pcint_pkg::pcint_ports_type pin_level,
    // Device sleep state
    input wire logic sleep_active,
    // Register bus
    input wire pcint_pkg::pcint_axi_req_type bus_req,
    output pcint_pkg::pcint_axi_rsp_type bus_rsp,
    // Interrupt and wake requests
    output logic irq,
    output logic wake_req
);

    // -------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------
    // Implemented bit positions per port
    localparam pcint_pkg::pcint_ports_type IMPL_MASK =
        {`PCINT_MASK_C, `PCINT_MASK_B, `PCINT_MASK_A};

    // Synchroniser stages and previous sample
    pcint_pkg::pcint_ports_type sync_first;
    pcint_pkg::pcint_ports_type sync_second;
    pcint_pkg::pcint_ports_type level_prev;
    // Edge enables and per-pin flags
    pcint_pkg::pcint_ports_type rise_en;
    pcint_pkg::pcint_ports_type fall_en;
    pcint_pkg::pcint_ports_type pin_change_flag_bits;
    pcint_pkg::pcint_ports_type next_rise_en;
    pcint_pkg::pcint_ports_type next_fall_en;
    pcint_pkg::pcint_ports_type next_flag;
    // Enabled edges found this cycle
    pcint_pkg::pcint_ports_type edge_hit;
    // Control bit and event status
    logic change_irq_master_enable;
    logic next_master_enable;
    logic [2:0] evt_status;
    logic [2:0] evt_mask;
    logic [2:0] next_evt_status;
    logic [2:0] next_evt_mask;
    logic [2:0] port_event;
    // Summary of all per-pin flags
    logic change_irq_summary_flag;
    logic next_irq;
    logic next_wake;

    // Bus slave state
    logic aw_held;
    logic w_held;
    logic [5:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane0;
    logic next_aw_held;
    logic next_w_held;
    logic [5:0] next_wr_addr;
    logic [7:0] next_wr_byte;
    logic next_wr_lane0;
    logic wr_fire;
    logic [7:0] wr_val;
    logic wr_hit;
    pcint_pkg::pcint_axi_rsp_type next_rsp;
    logic [7:0] rd_byte;
    logic rd_ok;

    // -------------------------------------------------------------
    // Pin sampling
    // -------------------------------------------------------------
    // Two flops per pin, then one more for the previous value
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_first <= '0;
            sync_second <= '0;
            level_prev <= '0;
        end else begin
            sync_first <= pin_level;
            sync_second <= sync_first;
            level_prev <= sync_second;
        end
    end

    // -------------------------------------------------------------
    // Edge detection
    // -------------------------------------------------------------
    // One detector pair per pin position of every port
    generate
        for (genvar p = 0; p < 3; p++) begin : g_port
            for (genvar b = 0; b < 8; b++) begin : g_pin
                // Rising and falling paths, each gated by its own enable
                assign edge_hit[p][b] = IMPL_MASK[p][b] &
                    ((rise_en[p][b] & sync_second[p][b] & ~level_prev[p][b]) |
                     (fall_en[p][b] & ~sync_second[p][b] & level_prev[p][b]));
            end
            // Any enabled edge on this port
            assign port_event[p] = |edge_hit[p];
        end
    endgenerate

    // -------------------------------------------------------------
    // Write decode
    // -------------------------------------------------------------
    // A write is performed once address and data are both held
    always_comb begin
        wr_fire = aw_held & w_held & ~bus_rsp.bvalid;
        wr_val = wr_lane0 ? wr_byte : `PCINT_RST_BYTE;
        wr_hit = wr_fire & wr_lane0;
    end

    // -------------------------------------------------------------
    // Enables, flags and control
    // -------------------------------------------------------------
    // Next values of all software visible state
    always_comb begin
        next_rise_en = rise_en;
        next_fall_en = fall_en;
        next_master_enable = change_irq_master_enable;
        next_evt_mask = evt_mask;
        next_flag = pin_change_flag_bits;
        next_evt_status = evt_status;
        // Register writes
        if (wr_hit) begin
            unique case (wr_addr)
                `PCINT_OFS_A_RISE: next_rise_en[0] = wr_val & IMPL_MASK[0];
                `PCINT_OFS_A_FALL: next_fall_en[0] = wr_val & IMPL_MASK[0];
                `PCINT_OFS_A_FLAG: next_flag[0] = wr_val & IMPL_MASK[0];
                `PCINT_OFS_B_RISE: next_rise_en[1] = wr_val & IMPL_MASK[1];
                `PCINT_OFS_B_FALL: next_fall_en[1] = wr_val & IMPL_MASK[1];
                `PCINT_OFS_B_FLAG: next_flag[1] = wr_val & IMPL_MASK[1];
                `PCINT_OFS_C_RISE: next_rise_en[2] = wr_val & IMPL_MASK[2];
                `PCINT_OFS_C_FALL: next_fall_en[2] = wr_val & IMPL_MASK[2];
                `PCINT_OFS_C_FLAG: next_flag[2] = wr_val & IMPL_MASK[2];
                `PCINT_OFS_CTRL: begin
                    next_master_enable = wr_val[`PCINT_BIT_MASTER_EN];
                end
                `PCINT_OFS_EVT_STAT: begin
                    // Write one to clear
                    next_evt_status = evt_status & ~wr_val[2:0];
                end
                `PCINT_OFS_EVT_MASK: next_evt_mask = wr_val[2:0];
                default: begin
                    // Unmapped: no state changes
                end
            endcase
        end
        // Hardware set wins over any write in the same cycle
        next_flag = next_flag | edge_hit;
        next_evt_status = next_evt_status | port_event;
    end

    // Registers of the software visible state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rise_en <= '0;
            fall_en <= '0;
            pin_change_flag_bits <= '0;
            change_irq_master_enable <= 1'b0;
            evt_status <= `PCINT_RST_EVT;
            evt_mask <= `PCINT_RST_EVT;
        end else begin
            rise_en <= next_rise_en;
            fall_en <= next_fall_en;
            pin_change_flag_bits <= next_flag;
            change_irq_master_enable <= next_master_enable;
            evt_status <= next_evt_status;
            evt_mask <= next_evt_mask;
        end
    end

    // -------------------------------------------------------------
    // Interrupt and wake
    // -------------------------------------------------------------
    // Interrupt follows the event status, wake the flag registers, so flags lead wake
    always_comb begin
        change_irq_summary_flag = |pin_change_flag_bits;
        next_irq = change_irq_master_enable &
            (|(evt_status & evt_mask));
        next_wake = change_irq_master_enable & sleep_active &
            change_irq_summary_flag;
    end

    // Request outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            irq <= next_irq;
            wake_req <= next_wake;
        end
    end

    // -------------------------------------------------------------
    // Read mux
    // -------------------------------------------------------------
    // Unimplemented bits read as zero
    always_comb begin
        rd_ok = 1'b1;
        // Low two address bits are ignored, as on the write side
        unique case ({bus_req.araddr[`PCINT_ADDR_MSB:`PCINT_ADDR_LSB], 2'h0})
            `PCINT_OFS_A_RISE: rd_byte = rise_en[0];
            `PCINT_OFS_A_FALL: rd_byte = fall_en[0];
            `PCINT_OFS_A_FLAG: rd_byte = pin_change_flag_bits[0];
            `PCINT_OFS_B_RISE: rd_byte = rise_en[1];
            `PCINT_OFS_B_FALL: rd_byte = fall_en[1];
            `PCINT_OFS_B_FLAG: rd_byte = pin_change_flag_bits[1];
            `PCINT_OFS_C_RISE: rd_byte = rise_en[2];
            `PCINT_OFS_C_FALL: rd_byte = fall_en[2];
            `PCINT_OFS_C_FLAG: rd_byte = pin_change_flag_bits[2];
            `PCINT_OFS_CTRL: begin
                rd_byte = `PCINT_RST_BYTE;
                rd_byte[`PCINT_BIT_MASTER_EN] = change_irq_master_enable;
                rd_byte[`PCINT_BIT_SUMMARY] = change_irq_summary_flag;
            end
            `PCINT_OFS_EVT_STAT: rd_byte = {5'h00, evt_status};
            `PCINT_OFS_EVT_MASK: rd_byte = {5'h00, evt_mask};
            default: begin
                rd_byte = `PCINT_RST_BYTE;
                rd_ok = 1'b0;
            end
        endcase
    end

    // -------------------------------------------------------------
    // Bus slave handshakes
    // -------------------------------------------------------------
    // Address and data are taken in either order, answered once both held
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_wr_addr = wr_addr;
        next_wr_byte = wr_byte;
        next_wr_lane0 = wr_lane0;
        next_rsp = bus_rsp;
        // Write address channel
        if (bus_req.awvalid & bus_rsp.awready) begin
            next_aw_held = 1'b1;
            next_wr_addr = {bus_req.awaddr[`PCINT_ADDR_MSB:`PCINT_ADDR_LSB], 2'h0};
        end
        // Write data channel, only the low lane carries register bits
        if (bus_req.wvalid & bus_rsp.wready) begin
            next_w_held = 1'b1;
            next_wr_byte = bus_req.wdata[7:0];
            next_wr_lane0 = bus_req.wstrb[0];
        end
        // Perform the write and raise the response
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_rsp.bvalid = 1'b1;
            next_rsp.bresp = `PCINT_RESP_OKAY;
            unique case (wr_addr)
                `PCINT_OFS_A_RISE, `PCINT_OFS_A_FALL, `PCINT_OFS_A_FLAG,
                `PCINT_OFS_B_RISE, `PCINT_OFS_B_FALL, `PCINT_OFS_B_FLAG,
                `PCINT_OFS_C_RISE, `PCINT_OFS_C_FALL, `PCINT_OFS_C_FLAG,
                `PCINT_OFS_CTRL, `PCINT_OFS_EVT_STAT,
                `PCINT_OFS_EVT_MASK: next_rsp.bresp = `PCINT_RESP_OKAY;
                default: next_rsp.bresp = `PCINT_RESP_SLVERR;
            endcase
        end else if (bus_rsp.bvalid & bus_req.bready) begin
            next_rsp.bvalid = 1'b0;
        end
        // Ready while nothing is held for that channel and no write response is pending
        next_rsp.awready = ~next_aw_held & ~next_rsp.bvalid;
        next_rsp.wready = ~next_w_held & ~next_rsp.bvalid;
        // Read channel: one read at a time
        if (bus_req.arvalid & bus_rsp.arready) begin
            next_rsp.rvalid = 1'b1;
            next_rsp.rdata = {24'h000000, rd_byte};
            next_rsp.rresp = rd_ok ? `PCINT_RESP_OKAY : `PCINT_RESP_SLVERR;
        end else if (bus_rsp.rvalid & bus_req.rready) begin
            next_rsp.rvalid = 1'b0;
        end
        next_rsp.arready = ~next_rsp.rvalid;
    end

    // Bus slave registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_byte <= `PCINT_RST_BYTE;
            wr_lane0 <= 1'b0;
            bus_rsp <= '0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wr_addr <= next_wr_addr;
            wr_byte <= next_wr_byte;
            wr_lane0 <= next_wr_lane0;
            bus_rsp <= next_rsp;
        end
    end

endmodule : pcint_top

// [tb_pin_change_interrupt.sv]
// Self-checking bench of the pin change block
`include "pcint_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_pin_change_interrupt;
    timeunit 1ns;
    timeprecision 1ps;
    // Bench signals
    logic clk_sys;
    logic rst_n;
    logic sleep_active;
    logic irq;
    logic wake_req;
    pcint_pkg::pcint_ports_type pin_req;
    pcint_pkg::pcint_ports_type pin_level;
    pcint_pkg::pcint_axi_req_type req;
    pcint_pkg::pcint_axi_rsp_type rsp;
    int fail_count = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'hC8838683;
    // Design and pin model
    pcint_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .pin_level(pin_level),
        .sleep_active(sleep_active), .bus_req(req), .bus_rsp(rsp), .irq(irq),
        .wake_req(wake_req));
    pci_pin_model u_pins (.clk_sys(clk_sys), .rst_n(rst_n), .pin_req(pin_req),
        .pin_level(pin_level));
    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Counts and verdict
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // Random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // Enabled edges between two levels
    function automatic logic [7:0] edges(input logic [7:0] rs, fl, o, n);
        return (rs & ~o & n) | (fl & o & ~n);
    endfunction : edges
    // Bus write, both channels offered together
    task automatic axi_wr(input logic [5:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        req.awaddr <= a;
        req.wdata <= {24'h000000, d};
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        req.bready <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : axi_wr
    // Bus read
    task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_sys);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : axi_rd
    // Every register reads zero and both requests are low after a reset
    task automatic check_reset_values();
        logic [31:0] d;
        logic [1:0] r;
        for (int a = 0; a <= 44; a += 4) begin
            axi_rd(6'(a), d, r);
            `CHK(d, 32'h00000000)
        end
        `CHK(irq, 1'b0)
        `CHK(wake_req, 1'b0)
    endtask : check_reset_values
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] rs;
        logic [7:0] fl;
        logic [2:0] msk;
        logic [2:0] ev;
        logic me;
        logic slp;
        logic sum;
        logic [7:0] pm [3];
        logic [7:0] ex [3];
        pcint_pkg::pcint_ports_type nv;
        pm = '{`PCINT_MASK_A, `PCINT_MASK_B, `PCINT_MASK_C};
        rst_n = 1'b0;
        sleep_active = 1'b0;
        req = '0;
        pin_req = '0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Reset values and an unmapped place
        check_reset_values();
        axi_rd(6'h30, d, r);
        `CHK(r, `PCINT_RESP_SLVERR)
        // Random enables and pin changes, first pass all enabled
        for (int it = 0; it < 24; it++) begin
            for (int p = 0; p < 3; p++) begin
                seed = lfsr_next(seed);
                rs = (it == 0) ? 8'hFF : seed[7:0];
                fl = (it == 0) ? 8'hFF : seed[15:8];
                nv[p] = (it == 0) ? ~pin_req[p] : seed[23:16];
                axi_wr(6'(12 * p), rs);
                axi_wr(6'(12 * p + 4), fl);
                axi_rd(6'(12 * p), d, r);
                `CHK(d[7:0], rs & pm[p])
                axi_rd(6'(12 * p + 8), d, r);
                axi_wr(6'(12 * p + 8), (d[7:0] ^ 8'hFF) & d[7:0]);
                axi_rd(6'(12 * p + 8), d, r);
                `CHK(d[7:0], 8'h00)
                ex[p] = edges(rs, fl, pin_req[p], nv[p]) & pm[p];
            end
            seed = lfsr_next(seed);
            me = (it == 0) | seed[24];
            msk = (it == 0) ? 3'h7 : seed[27:25];
            slp = seed[28];
            axi_wr(`PCINT_OFS_EVT_STAT, 8'h07);
            axi_wr(`PCINT_OFS_CTRL, {7'h00, me});
            axi_wr(`PCINT_OFS_EVT_MASK, {5'h00, msk});
            @(posedge clk_sys);
            sleep_active <= slp;
            pin_req <= nv;
            repeat (8) @(posedge clk_sys);
            ev = {|ex[2], |ex[1], |ex[0]};
            sum = |ev;
            `CHK(irq, me & |(ev & msk))
            `CHK(wake_req, me & slp & sum)
            for (int p = 0; p < 3; p++) begin
                axi_rd(6'(12 * p + 8), d, r);
                `CHK(d[7:0], ex[p])
            end
            axi_rd(`PCINT_OFS_CTRL, d, r);
            `CHK(d[1:0], {sum, me})
            axi_rd(`PCINT_OFS_EVT_STAT, d, r);
            `CHK(d[2:0], ev)
        end
        // Edge lands on the same edge as a flag clear: the set wins
        axi_wr(`PCINT_OFS_C_RISE, 8'h01);
        axi_wr(`PCINT_OFS_C_FALL, 8'h01);
        axi_wr(`PCINT_OFS_C_FLAG, 8'h00);
        @(posedge clk_sys);
        pin_req[2][0] <= ~pin_req[2][0];
        @(posedge clk_sys);
        // Pin edge reaches the flag four edges on, the write three edges into the task
        axi_wr(`PCINT_OFS_C_FLAG, 8'h00);
        axi_rd(`PCINT_OFS_C_FLAG, d, r);
        `CHK(d[7:0], 8'h01)
        // Same meeting on the event status write-one-to-clear
        @(posedge clk_sys);
        pin_req[2][0] <= ~pin_req[2][0];
        @(posedge clk_sys);
        axi_wr(`PCINT_OFS_EVT_STAT, 8'h07);
        axi_rd(`PCINT_OFS_EVT_STAT, d, r);
        `CHK(d[2:0], 3'h4)
        // Reset in mid-run clears all that was set above
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        check_reset_values();
        tally_and_finish();
    end
endmodule : tb_pin_change_interrupt
